// *** verilog/ptt_pkg.sv ***
// Shared constants and types for the periodic tick timer and clock-select block.
package ptt_pkg;

   // Register indices; the byte address of each register is four times its index.
   localparam logic [5:0] IDX_STATUS = 6'h37;
   localparam logic [5:0] IDX_WRITE_PROTECTION_FLAG = 6'h38;
   localparam logic [5:0] IDX_CSEL = 6'h39;
   localparam logic [5:0] IDX_PLL = 6'h3a;
   localparam logic [5:0] IDX_TICK = 6'h3b;

   // Bit positions in the clock-source select register.
   localparam int CSEL_PLL_SEL = 7;
   localparam int CSEL_PSEUDO_STOP = 6;
   localparam int CSEL_WD_HIGH = 4;
   localparam int CSEL_TICK_SEL = 1;
   localparam int CSEL_WD_LOW = 0;

   // Bit positions in the PLL control, protection and status registers.
   localparam int PLL_FM_HIGH = 5;
   localparam int PLL_FM_LOW = 4;
   localparam int WRITE_PROTECTION_FLAG_FLAG = 0;
   localparam int ST_TICK = 0;
   localparam int ST_LOCK = 1;
   localparam int ST_OSC_UP = 2;
   localparam int ST_STOP = 3;

   // Bit positions in the tick timer control register.
   localparam int TICK_DEC = 7;
   localparam int TICK_PRE_HI = 6;
   localparam int TICK_PRE_LO = 4;
   localparam int TICK_MOD_HI = 3;

   // Reset values.
   localparam logic [7:0] CSEL_RST = 8'h80;
   localparam logic [7:0] PLL_RST = 8'h00;
   localparam logic [7:0] TICK_RST = 8'h00;
   localparam logic [7:0] WRITE_PROTECTION_FLAG_RST = 8'h00;

   // Divider chain sizing and prescale tables.
   localparam int PRE_W = 18;
   localparam int MOD_W = 4;
   localparam int BIN_BASE_SHIFT = 9;
   localparam logic [PRE_W-1:0] DEC_PRE [8] = '{18'h0_03e8, 18'h0_07d0, 18'h0_1388, 18'h0_2710,
                                                18'h0_4e20, 18'h0_c350, 18'h1_86a0, 18'h3_0d40};

   // Frequency modulation runs at the reference rate divided by this figure.
   localparam int FM_DIV = 16;
   localparam int FM_W = 4;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Clock-source select fields travel together.
   typedef struct packed {
      logic pll_sel;
      logic pseudo_stop;
      logic wd_high;
      logic tick_sel;
      logic wd_low;
   } ptt_csel_s;

   // Watchdog clock source.
   typedef enum logic [1:0] {PTT_WD_IRC, PTT_WD_OSC, PTT_WD_AUX} ptt_wd_src_e;

endpackage

// *** verilog/ptt_sync.sv ***
`timescale 1ns/100ps
// Two-stage synchroniser for a group of asynchronous level inputs.
module ptt_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Asynchronous levels in, synchronised levels out.
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_ff; // First stage; read only by the second stage.

   // Both stages clear on reset: a quiet input at release.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_ff <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end

endmodule

// *** verilog/ptt_tick_div.sv ***
`timescale 1ns/100ps
// Prescaler followed by a modulus counter; emits one tick per full period.
module ptt_tick_div #(
   parameter int PW = 18,
   parameter int MW = 4
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Control.
   input wire logic restart,
   input wire logic step,
   input wire logic [PW-1:0] period_len,
   input wire logic [MW-1:0] modulus,
   // Result.
   output logic tick
);

   logic [PW-1:0] pre_ff; // Prescaler position.
   logic [MW-1:0] mod_ff; // Modulus position.

   // Zero length is off; counters hold at zero for a clean start.
   always_ff @(posedge aclk)
   begin
      tick <= 1'b0;
      if (!aresetn || restart || period_len == '0)
      begin
         pre_ff <= '0;
         mod_ff <= '0;
      end
      else if (step)
      begin
         if (pre_ff == period_len - PW'(1))
         begin
            pre_ff <= '0;
            // Period is prescale length times modulus plus one.
            if (mod_ff == modulus) // RL17
            begin
               mod_ff <= '0;
               tick <= 1'b1; // RL20
            end
            else
            begin
               mod_ff <= mod_ff + MW'(1);
            end
         end
         else
         begin
            pre_ff <= pre_ff + PW'(1);
         end
      end
      if (!aresetn)
      begin
         tick <= 1'b0;
      end
   end

endmodule

// *** verilog/ptt_top.sv ***
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
// Contract
// RL1: Select bit one picks tick clock source.
// RL2: Tick select change restarts the period.
// RL3: Tick select needs oscillator up, else cleared.
// RL4: Two bits choose watchdog clock source.
// RL5: High bit set: low bit is ignored.
// RL6: High bit clear: low change restarts watchdog.
// RL7: Watchdog low bit needs oscillator up.
// RL8: PLL writes need unprotected and PLL selected.
// RL9: PLL write clears lock and oscillator status.
// RL10: Modulation rate is reference over sixteen.
// RL11: Amplitude code: off, one, two, four percent.
// RL12: Stop halts tick unless pseudo-stop with oscillator.
// RL13: Tick control write starts a new period.
// RL14: Tick control always readable and writable.
// RL15: Bit seven picks binary or decimal divider.
// RL16: Binary prescale: off, then two^10..two^16.
// RL17: Modulus multiplies prescale by value plus one.
// RL18: Decimal prescale table from 1000 to 200000.
// RL19: Tick control resets to all off.
// RL20: Each period end sets flag and repeats.
module ptt_top
   import ptt_pkg::*;
#(
   parameter int AW = 8
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address channel.
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data channel.
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address channel.
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Asynchronous status and clock inputs from the clock system.
   input wire logic stop_mode,
   input wire logic oscillator_qualified,
   input wire logic pll_lock_detect,
   input wire logic internal_rc_clock,
   input wire logic external_oscillator_clock,
   input wire logic pll_reference_clock,
   // Tick timer result.
   output logic tick_event,
   // Watchdog clock control.
   output ptt_wd_src_e watchdog_source,
   output logic watchdog_restart,
   // PLL and status outputs.
   output logic pll_clock_selection,
   output logic oscillator_up_status,
   output logic pll_lock_status,
   output logic [1:0] fm_amplitude,
   output logic fm_step
);

   // Synchronised inputs and their previous values for edge detection.
   logic [5:0] sync_in;
   logic [5:0] prev_ff;
   logic [5:0] rise;
   logic stop_s;
   logic oscq_s;
   logic lock_s;

   // Bus slave state.
   logic aw_held_ff;
   logic [5:0] aw_idx_ff;
   logic w_held_ff;
   logic [7:0] wdata_ff;
   logic wlane_ff;
   logic wr_go;
   logic wr_ok;
   logic [5:0] ar_idx;
   logic [7:0] rd_val;
   logic rd_ok;

   // Register contents.
   ptt_csel_s csel_ff;
   logic [7:0] pll_ff;
   logic [7:0] tick_ctl_ff;
   logic write_protection_flag_ff;
   logic tick_flag_ff;
   logic tick_sel_prev_ff;
   logic wd_high_prev_ff;
   logic wd_low_prev_ff;
   logic [FM_W-1:0] fm_cnt_ff;

   // Write strobes per register.
   logic we_csel;
   logic we_pll;
   logic we_tick;
   logic we_write_protection_flag;
   logic we_status;
   logic pll_write_taken;

   // Tick timer control.
   logic tick_restart;
   logic tick_run;
   logic tick_step;
   logic tick_pulse;
   logic [PRE_W-1:0] period_len;

   ptt_sync #(
      .W(6)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({pll_reference_clock, external_oscillator_clock, internal_rc_clock,
                 pll_lock_detect, oscillator_qualified, stop_mode}),
      .sync_out(sync_in)
   );

   assign stop_s = sync_in[0];
   assign oscq_s = sync_in[1];
   assign lock_s = sync_in[2];
   assign rise = sync_in & ~prev_ff;

   // Previous synchronised values, taken after the second stage only.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prev_ff <= '0;
      end
      else
      begin
         prev_ff <= sync_in;
      end
   end

   // AW and W are held apart; the write fires once both are in.
   assign s_axi_awready = !aw_held_ff;
   assign s_axi_wready = !w_held_ff;
   assign wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;

   // Only the lowest byte lane carries register data.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_ff <= 1'b0;
         aw_idx_ff <= '0;
         w_held_ff <= 1'b0;
         wdata_ff <= '0;
         wlane_ff <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_ff <= 1'b1;
            aw_idx_ff <= s_axi_awaddr[7:2];
         end
         else if (wr_go)
         begin
            aw_held_ff <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata[7:0];
            wlane_ff <= s_axi_wstrb[0];
         end
         else if (wr_go)
         begin
            w_held_ff <= 1'b0;
         end
      end
   end

   // Known indices answer OKAY, anything else SLVERR.
   assign wr_ok = (aw_idx_ff inside {IDX_STATUS, IDX_WRITE_PROTECTION_FLAG, IDX_CSEL, IDX_PLL, IDX_TICK});

   // Write response; no new write fires while one waits.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign we_csel = wr_go && wlane_ff && aw_idx_ff == IDX_CSEL;
   assign we_pll = wr_go && wlane_ff && aw_idx_ff == IDX_PLL;
   assign we_tick = wr_go && wlane_ff && aw_idx_ff == IDX_TICK;
   assign we_write_protection_flag = wr_go && wlane_ff && aw_idx_ff == IDX_WRITE_PROTECTION_FLAG;
   assign we_status = wr_go && wlane_ff && aw_idx_ff == IDX_STATUS;
   // A blocked write still gets OKAY, but changes nothing.
   assign pll_write_taken = we_pll && !write_protection_flag_ff && csel_ff.pll_sel; // RL8

   // Oscillator-up status: qualified edge sets, loss or a taken PLL write clears; set wins.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         oscillator_up_status <= 1'b0;
      end
      else if (rise[1])
      begin
         oscillator_up_status <= 1'b1;
      end
      else if (pll_write_taken || !oscq_s)
      begin
         oscillator_up_status <= 1'b0; // RL9
      end
   end

   // Lock status behaves the same way against the lock detector.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pll_lock_status <= 1'b0;
      end
      else if (rise[2])
      begin
         pll_lock_status <= 1'b1;
      end
      else if (pll_write_taken || !lock_s)
      begin
         pll_lock_status <= 1'b0; // RL9
      end
   end

   // Clock-source select register with oscillator-dependent gating.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         csel_ff <= '{pll_sel: CSEL_RST[CSEL_PLL_SEL], pseudo_stop: CSEL_RST[CSEL_PSEUDO_STOP],
                      wd_high: CSEL_RST[CSEL_WD_HIGH], tick_sel: CSEL_RST[CSEL_TICK_SEL],
                      wd_low: CSEL_RST[CSEL_WD_LOW]};
      end
      else if (!oscillator_up_status)
      begin
         // Losing the oscillator drops both oscillator selections and forces the PLL path.
         csel_ff.tick_sel <= 1'b0; // RL3
         csel_ff.wd_low <= 1'b0; // RL7
         csel_ff.pll_sel <= 1'b1;
         if (we_csel)
         begin
            csel_ff.pseudo_stop <= wdata_ff[CSEL_PSEUDO_STOP];
            csel_ff.wd_high <= wdata_ff[CSEL_WD_HIGH];
         end
      end
      else if (we_csel)
      begin
         csel_ff.pll_sel <= wdata_ff[CSEL_PLL_SEL];
         csel_ff.pseudo_stop <= wdata_ff[CSEL_PSEUDO_STOP];
         csel_ff.wd_high <= wdata_ff[CSEL_WD_HIGH];
         csel_ff.tick_sel <= wdata_ff[CSEL_TICK_SEL]; // RL3
         csel_ff.wd_low <= wdata_ff[CSEL_WD_LOW]; // RL7
      end
   end

   // PLL control register; amplitude code drives the modulator.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pll_ff <= PLL_RST;
      end
      else if (pll_write_taken)
      begin
         pll_ff <= wdata_ff; // RL8
      end
   end

   // Protection flag, and the tick control register which has no write condition.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         write_protection_flag_ff <= WRITE_PROTECTION_FLAG_RST[WRITE_PROTECTION_FLAG_FLAG];
         tick_ctl_ff <= TICK_RST; // RL19
      end
      else
      begin
         if (we_write_protection_flag)
         begin
            write_protection_flag_ff <= wdata_ff[WRITE_PROTECTION_FLAG_FLAG];
         end
         if (we_tick)
         begin
            tick_ctl_ff <= wdata_ff; // RL14
         end
      end
   end

   // Previous selections, to see any change.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tick_sel_prev_ff <= CSEL_RST[CSEL_TICK_SEL];
         wd_high_prev_ff <= CSEL_RST[CSEL_WD_HIGH];
         wd_low_prev_ff <= CSEL_RST[CSEL_WD_LOW];
      end
      else
      begin
         tick_sel_prev_ff <= csel_ff.tick_sel;
         wd_high_prev_ff <= csel_ff.wd_high;
         wd_low_prev_ff <= csel_ff.wd_low;
      end
   end

   // Watchdog source and restart; the low bit only counts while the high bit is clear.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         watchdog_source <= PTT_WD_IRC;
         watchdog_restart <= 1'b0;
      end
      else
      begin
         if (csel_ff.wd_high)
         begin
            watchdog_source <= PTT_WD_AUX; // RL4
         end
         else
         begin
            watchdog_source <= csel_ff.wd_low ? PTT_WD_OSC : PTT_WD_IRC; // RL4
         end
         watchdog_restart <= (csel_ff.wd_high != wd_high_prev_ff)
                             || (!csel_ff.wd_high && (csel_ff.wd_low != wd_low_prev_ff)); // RL6 RL5
      end
   end

   // Prescale length from the divider family and code; a binary code of zero means off.
   always_comb
   begin
      period_len = '0;
      if (tick_ctl_ff[TICK_DEC]) // RL15
      begin
         period_len = DEC_PRE[tick_ctl_ff[TICK_PRE_HI:TICK_PRE_LO]]; // RL18
      end
      else if (tick_ctl_ff[TICK_PRE_HI:TICK_PRE_LO] != 3'h0) // RL16
      begin
         period_len = PRE_W'(1) << (BIN_BASE_SHIFT + int'(tick_ctl_ff[TICK_PRE_HI:TICK_PRE_LO])); // RL16
      end
   end

   // Restart on a control write or any change of the tick clock selection.
   assign tick_restart = we_tick || (csel_ff.tick_sel != tick_sel_prev_ff); // RL13 RL2
   // In stop mode only pseudo-stop on the oscillator keeps counting; halting keeps the count.
   assign tick_run = !stop_s || (csel_ff.pseudo_stop && csel_ff.tick_sel); // RL12
   assign tick_step = tick_run && (csel_ff.tick_sel ? rise[4] : rise[3]); // RL1

   ptt_tick_div #(
      .PW(PRE_W),
      .MW(MOD_W)
   ) u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .restart(tick_restart),
      .step(tick_step),
      .period_len(period_len),
      .modulus(tick_ctl_ff[TICK_MOD_HI:0]),
      .tick(tick_pulse)
   );

   // Tick flag is sticky; writing one clears it, but a tick in the same cycle wins.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tick_flag_ff <= 1'b0;
         tick_event <= 1'b0;
      end
      else
      begin
         tick_event <= tick_pulse;
         if (tick_pulse)
         begin
            tick_flag_ff <= 1'b1; // RL20
         end
         else if (we_status && wdata_ff[ST_TICK])
         begin
            tick_flag_ff <= 1'b0;
         end
      end
   end

   // Modulator: one step per sixteen reference edges.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fm_cnt_ff <= '0;
         fm_step <= 1'b0;
         fm_amplitude <= 2'h0;
      end
      else
      begin
         fm_amplitude <= {pll_ff[PLL_FM_HIGH], pll_ff[PLL_FM_LOW]}; // RL11
         fm_step <= 1'b0;
         if (fm_amplitude == 2'h0)
         begin
            fm_cnt_ff <= '0; // RL11
         end
         else if (rise[5])
         begin
            fm_cnt_ff <= fm_cnt_ff + FM_W'(1);
            fm_step <= (fm_cnt_ff == FM_W'(FM_DIV - 1)); // RL10
         end
      end
   end

   assign pll_clock_selection = csel_ff.pll_sel;

   // Read mux; unknown indices read zero and answer SLVERR.
   assign ar_idx = s_axi_araddr[7:2];
   always_comb
   begin
      rd_val = 8'h00;
      rd_ok = 1'b1;
      case (ar_idx)
         IDX_STATUS: rd_val = {4'h0, stop_s, oscillator_up_status, pll_lock_status, tick_flag_ff};
         IDX_WRITE_PROTECTION_FLAG: rd_val = {7'h00, write_protection_flag_ff};
         IDX_CSEL: rd_val = {csel_ff.pll_sel, csel_ff.pseudo_stop, 1'b0, csel_ff.wd_high,
                             2'h0, csel_ff.tick_sel, csel_ff.wd_low};
         IDX_PLL: rd_val = pll_ff;
         IDX_TICK: rd_val = tick_ctl_ff; // RL14
         default: rd_ok = 1'b0;
      endcase
   end

   // Read channel: address taken only while no data waits.
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_val};
         s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// *** test/ptt_top_chk.sv ***
`timescale 1ns/100ps
// Checks bus handshakes and derived outputs.
module ptt_top_chk
   import ptt_pkg::*;
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshake signals.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Tick, watchdog and modulation outputs.
   input wire logic tick_event,
   input wire ptt_wd_src_e watchdog_source,
   input wire logic watchdog_restart,
   input wire logic oscillator_up_status,
   input wire logic [1:0] fm_amplitude,
   input wire logic fm_step
);
   // One clock, one reset.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bresp not held");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rdata not held");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
      |-> ##2 s_axi_bvalid)
      else $error("write response late");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000)
      else $error("read answer bad");
   aw_take_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("awready while held");
   tick_pulse_a: assert property (tick_event |=> (!tick_event) [*8])
      else $error("tick pulses too close");
   fm_gap_a: assert property (fm_step |=> (!fm_step) [*8])
      else $error("fm steps too close");
   fm_off_a: assert property ((fm_amplitude == 2'h0) [*3] |-> !fm_step)
      else $error("fm step while off");
   wd_restart_a: assert property ($changed(watchdog_source) |-> ##[0:2] watchdog_restart)
      else $error("wd change without restart");
   wd_osc_a: assert property ((!oscillator_up_status) [*4] |-> watchdog_source != PTT_WD_OSC)
      else $error("wd on lost oscillator");

   // Main scenarios.
   cover property (tick_event);
   cover property (fm_step);
   cover property (watchdog_restart);
   cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind ptt_top ptt_top_chk chk (.*);

// *** test/test_periodic_tick_timer_clock_select.sv ***
`timescale 1ns/100ps
// Register-level bench for the tick timer and clock-select block.
module test_periodic_tick_timer_clock_select;
   import ptt_pkg::*;
   // Bus cycles per period of each slow clock.
   localparam int IRC_CYC = 4;
   localparam int XOSC_CYC = 6;
   localparam int REF_CYC = 4;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic stop_mode = 1'b0, osc_q = 1'b0, lock_det = 1'b0, irc = 1'b0, xosc = 1'b0, ref_clk = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, tick_event, wd_restart, pll_sel, osc_up, lock, fm_step;
   logic [1:0] bresp, rresp, fm_amp;
   logic [31:0] rdata;
   ptt_wd_src_e wd_src;
   int cyc = 0, error_cnt = 0, total_checks = 0, tick_cnt = 0, rst_cnt = 0;
   // Divider settings and lengths in clock edges.
   logic [7:0] tc [3] = '{8'h10, 8'h11, 8'h80};
   int tl [3] = '{1024, 2048, 1000};
   // Select writes, expected watchdog source and restarts.
   logic [7:0] cs [4] = '{8'h03, 8'h13, 8'h12, 8'h83};
   ptt_wd_src_e src [4] = '{PTT_WD_OSC, PTT_WD_AUX, PTT_WD_AUX, PTT_WD_OSC};
   int rs [4] = '{1, 1, 0, 1};

   ptt_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(s_axi_rready),
      .stop_mode(stop_mode), .oscillator_qualified(osc_q), .pll_lock_detect(lock_det),
      .internal_rc_clock(irc), .external_oscillator_clock(xosc), .pll_reference_clock(ref_clk),
      .tick_event(tick_event), .watchdog_source(wd_src), .watchdog_restart(wd_restart),
      .pll_clock_selection(pll_sel), .oscillator_up_status(osc_up), .pll_lock_status(lock),
      .fm_amplitude(fm_amp), .fm_step(fm_step));

   always #12.5 aclk = ~aclk;

   // Slow clocks, counters and hang limit.
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      irc <= cyc[1];
      xosc <= (cyc % 6) < 3;
      ref_clk <= cyc[1];
      tick_cnt <= tick_cnt + tick_event;
      rst_cnt <= rst_cnt + wd_restart;
      if (cyc == 90000)
      begin
         error_cnt = error_cnt + 1;
         results();
      end
   end

   // One comparison.
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   // Write: AW and W together, each held until taken.
   task automatic axw(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er);
      logic a, w;
      @(posedge aclk);
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      a = 1'b0;
      w = 1'b0;
      do
      begin
         @(posedge aclk);
         if (!a && awready)
         begin
            a = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && wready)
         begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end while (!bvalid);
      cmp("write response", er, bresp);
      s_axi_bready <= 1'b0;
   endtask

   // Read: address held until taken, data taken with rvalid.
   task automatic rdc(input logic [5:0] i, input logic [7:0] e, input logic [1:0] er);
      logic a;
      @(posedge aclk);
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      a = 1'b0;
      do
      begin
         @(posedge aclk);
         if (!a && arready)
         begin
            a = 1'b1;
            s_axi_arvalid <= 1'b0;
         end
      end while (!rvalid);
      cmp($sformatf("register %h", i), {24'h00_0000, e}, rdata);
      cmp("read response", er, rresp);
      s_axi_rready <= 1'b0;
   endtask

   // Waits for the next tick.
   task automatic next_tick(output int t);
      do @(posedge aclk); while (tick_event !== 1'b1);
      t = cyc;
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      int t0, t1, r0, n0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(IDX_TICK, TICK_RST, RESP_OKAY);
      rdc(IDX_CSEL, CSEL_RST, RESP_OKAY);
      rdc(IDX_PLL, PLL_RST, RESP_OKAY);
      cmp("pll select", 1, pll_sel);
      rdc(6'h00, 8'h00, RESP_SLVERR);
      axw(6'h00, 8'h5a, RESP_SLVERR);
      axw(IDX_TICK, 8'ha5, RESP_OKAY);
      rdc(IDX_TICK, 8'ha5, RESP_OKAY);
      $display("test reset and access done");
      foreach (tc[k])
      begin
         axw(IDX_TICK, tc[k], RESP_OKAY);
         next_tick(t0);
         next_tick(t1);
         cmp("tick period", tl[k] * IRC_CYC, t1 - t0);
      end
      rdc(IDX_STATUS, 8'h01, RESP_OKAY);
      // A mid-period rewrite restarts the period.
      axw(IDX_TICK, 8'h10, RESP_OKAY);
      next_tick(t0);
      repeat (2000) @(posedge aclk);
      axw(IDX_TICK, 8'h10, RESP_OKAY);
      t0 = cyc;
      next_tick(t1);
      cmp("restart", 1, (t1 - t0 > 4080) && (t1 - t0 < 4112));
      stop_mode <= 1'b1;
      @(posedge aclk);
      n0 = tick_cnt;
      repeat (4500) @(posedge aclk);
      cmp("ticks in stop", n0, tick_cnt);
      stop_mode <= 1'b0;
      axw(IDX_TICK, 8'h0f, RESP_OKAY);
      @(posedge aclk);
      n0 = tick_cnt;
      repeat (4500) @(posedge aclk);
      cmp("ticks when off", n0, tick_cnt);
      $display("test tick divider done");
      axw(IDX_CSEL, 8'h83, RESP_OKAY);
      rdc(IDX_CSEL, 8'h80, RESP_OKAY);
      osc_q <= 1'b1;
      lock_det <= 1'b1;
      repeat (8) @(posedge aclk);
      cmp("osc up", 1, osc_up);
      cmp("lock up", 1, lock);
      foreach (cs[k])
      begin
         r0 = rst_cnt;
         axw(IDX_CSEL, cs[k], RESP_OKAY);
         repeat (4) @(posedge aclk);
         rdc(IDX_CSEL, cs[k], RESP_OKAY);
         cmp("wd source", src[k], wd_src);
         cmp("wd restarts", rs[k], rst_cnt - r0);
         if (k == 2)
         begin
            axw(IDX_PLL, 8'h30, RESP_OKAY);
            rdc(IDX_PLL, PLL_RST, RESP_OKAY);
         end
      end
      axw(IDX_TICK, 8'h10, RESP_OKAY);
      next_tick(t0);
      next_tick(t1);
      cmp("osc tick period", 1024 * XOSC_CYC, t1 - t0);
      $display("test clock select done");
      axw(IDX_WRITE_PROTECTION_FLAG, 8'h01, RESP_OKAY);
      axw(IDX_PLL, 8'h30, RESP_OKAY);
      rdc(IDX_PLL, PLL_RST, RESP_OKAY);
      axw(IDX_WRITE_PROTECTION_FLAG, 8'h00, RESP_OKAY);
      for (int a = 0; a < 4; a++)
      begin
         axw(IDX_PLL, {2'h0, a[1:0], 4'h1}, RESP_OKAY);
         repeat (2) @(posedge aclk);
         cmp("fm amplitude", a, fm_amp);
      end
      rdc(IDX_PLL, 8'h31, RESP_OKAY);
      cmp("osc up cleared", 0, osc_up);
      cmp("lock cleared", 0, lock);
      rdc(IDX_CSEL, 8'h80, RESP_OKAY);
      cmp("wd source", PTT_WD_IRC, wd_src);
      do @(posedge aclk); while (fm_step !== 1'b1);
      t0 = cyc;
      do @(posedge aclk); while (fm_step !== 1'b1);
      cmp("fm period", FM_DIV * REF_CYC, cyc - t0);
      $display("test pll control done");
      results();
   end
endmodule
